// ---- src/vic_capture.sv ----
// Purpose: Video input capture, port routing and formatting front end.
// Assumes: Registers on ref_clk over Avalon-MM; capture on the pixel clock.
// Notes:   Config crosses by toggle handshake and is applied at a frame boundary, or at once while capture is disabled.
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module vic_capture (
  // System clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Register bus.
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Address straps and captured target address bits.
  input  wire logic        target_addr_strap0,
  input  wire logic        target_addr_strap1,
  output logic [1:0]       target_addr_lsb,
  // Video source, timed by the pixel clock.
  input  wire logic        pixel_clock_in,
  input  wire logic [7:0]  pixel_port_a,
  input  wire logic [7:0]  pixel_port_b,
  input  wire logic [7:0]  pixel_port_c,
  input  wire logic        line_sync_in,
  input  wire logic        frame_sync_in,
  input  wire logic        active_video_in,
  // Formatted pixels toward the encoder.
  output logic [11:0]      pix_ch0,
  output logic [11:0]      pix_ch1,
  output logic [11:0]      pix_ch2,
  output logic             pix_odd,
  output logic             pix_valid,
  output logic             frame_start
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // The stream operator may only feed an assignment, so it sits alone here.
  function automatic logic [7:0] rev8(logic [7:0] x);
    rev8 = {<<{x}};
  endfunction

  function automatic logic [7:0] pick(logic [1:0] s, logic r,
      logic [7:0] a, logic [7:0] b, logic [7:0] c);
    logic [7:0] v;
    v = (s == 2'h1) ? b : (s == 2'h2) ? c : a;
    pick = r ? rev8(v) : v;
  endfunction

  function automatic logic [23:0] route(vic_pkg::vic_map_t m,
      logic [7:0] a, logic [7:0] b, logic [7:0] c);
    route = {pick(m.s2, m.rev[2], a, b, c), pick(m.s1, m.rev[1], a, b, c),
             pick(m.s0, m.rev[0], a, b, c)};
  endfunction

  // Strict mode also checks the protection bits of the timing word.
  function automatic logic xy_ok(logic [7:0] x, logic st);
    logic [3:0] p;
    p = {x[5] ^ x[4], x[6] ^ x[4], x[6] ^ x[5], x[6] ^ x[5] ^ x[4]};
    xy_ok = x[7] && (!st || x[3:0] == p);
  endfunction

  function automatic logic [17:0] lim(vic_pkg::vic_ctl_t c);
    case (c.fmt)
      vic_pkg::FMT_ITL: begin
        lim = (c.edg == vic_pkg::EDG_DBL) ? vic_pkg::KHZ_DBL
                                          : vic_pkg::KHZ_ITL;
      end
      vic_pkg::FMT_SEMI: lim = vic_pkg::KHZ_SEMI;
      default:           lim = vic_pkg::KHZ_444;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------------
  typedef struct packed {
    vic_pkg::vic_ctl_t ctl;
    vic_pkg::vic_map_t map;
    vic_pkg::vic_ctl_t sctl;
    vic_pkg::vic_map_t smap;
    logic              req;
    logic              dirty;
    logic              wt;
    logic [31:0]       rdata;
    logic [1:0]        strap;
    logic              sok;
    logic [1:0]        sdly;
    logic              fseen;
    logic [7:0]        fcnt;
    logic [10:0]       lines;
  } vic_ref_t;

  typedef struct packed {
    vic_pkg::vic_ctl_t ctl;
    vic_pkg::vic_map_t map;
    vic_pkg::vic_ctl_t pctl;
    vic_pkg::vic_map_t pmap;
    logic              pend;
    logic              ack;
    logic [3:0][7:0]   key;
    logic [11:0]       chr;
    logic [1:0]        ph;
    logic              act;
    logic              vb;
    logic              vs;
    logic              hs;
    logic [10:0]       lcnt;
    logic [10:0]       lines;
    logic              ftg;
    logic [11:0]       c0;
    logic [11:0]       c1;
    logic [11:0]       c2;
    logic              odd;
    logic              vld;
    logic              fst;
  } vic_pix_t;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
    logic       de;
  } vic_neg_t;

  vic_ref_t    rq;
  vic_ref_t    rd;
  vic_pix_t    pq;
  vic_pix_t    pd;
  vic_neg_t    nq;
  logic [3:0]  rsync;
  logic        req_s;
  logic        bnd;

  // ----------------------------------------------------------------------
  // Clock crossings
  // ----------------------------------------------------------------------
  vic_sync2 #(.W(4)) u_ref_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .d     ({target_addr_strap1, target_addr_strap0, pq.ack, pq.ftg}),
    .q     (rsync)
  );

  vic_sync2 #(.W(1)) u_pix_sync (
    .clk   (pixel_clock_in),
    .rst_n (rst_n),
    .d     (rq.req),
    .q     (req_s)
  );

  // ----------------------------------------------------------------------
  // Register bus and system-side state
  // ----------------------------------------------------------------------
  // Every access takes one wait state; read data is loaded during it.
  always_comb begin
    logic       req;
    logic       busy;
    logic [4:0] ba;
    req  = avs_read || avs_write;
    busy = rq.req != rsync[1];
    ba   = {avs_address, 2'b00};
    rd   = rq;
    rd.wt = !(req && rq.wt);
    if (req && rq.wt) begin
      case (ba)
        vic_pkg::OFF_CTRL: rd.rdata = {25'h0, rq.ctl};
        vic_pkg::OFF_MAP:  rd.rdata = {23'h0, rq.map};
        vic_pkg::OFF_STAT: rd.rdata = {5'h0, rq.lines, rq.fcnt, 5'h0,
                                       rq.strap, busy};
        vic_pkg::OFF_LIM:  rd.rdata = {14'h0, lim(rq.ctl)};
        default:           rd.rdata = 32'h0;
      endcase
    end
    // Snapshot stays still until the pixel side acknowledges it.
    if (rq.dirty && !busy) begin
      rd.sctl  = rq.ctl;
      rd.smap  = rq.map;
      rd.req   = !rq.req;
      rd.dirty = 1'b0;
    end
    // A write in the snapshot cycle sets dirty again, so it is never lost.
    if (avs_write && !rq.wt) begin
      if (ba == vic_pkg::OFF_CTRL) begin
        rd.ctl   = vic_pkg::vic_ctl_t'(avs_writedata[6:0]);
        rd.dirty = 1'b1;
      end else if (ba == vic_pkg::OFF_MAP) begin
        rd.map   = vic_pkg::vic_map_t'(avs_writedata[8:0]);
        rd.dirty = 1'b1;
      end
    end
    // Straps settle through the synchroniser before being caught once.
    if (!rq.sok) begin
      if (rq.sdly == vic_pkg::STRAP_WAIT) begin
        rd.strap = rsync[3:2];
        rd.sok   = 1'b1;
      end else begin
        rd.sdly = rq.sdly + 2'h1;
      end
    end
    // The line total is held a whole frame, so it is safe to take here.
    if (rsync[0] != rq.fseen) begin
      rd.fseen = rsync[0];
      rd.fcnt  = rq.fcnt + 8'h01;
      rd.lines = pq.lines;
    end
  end

  // System-side state register.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rq       <= '0;
      rq.ctl   <= vic_pkg::CTL_RST;
      rq.map   <= vic_pkg::MAP_RST;
      rq.sctl  <= vic_pkg::CTL_RST;
      rq.smap  <= vic_pkg::MAP_RST;
      rq.wt    <= 1'b1;
    end else begin
      rq <= rd;
    end
  end

  // ----------------------------------------------------------------------
  // Pixel capture
  // ----------------------------------------------------------------------
  // Falling-edge samples, used for falling and double-edge capture.
  always_ff @(negedge pixel_clock_in or negedge rst_n) begin
    if (!rst_n) begin
      nq <= '0;
    end else begin
      nq <= {pixel_port_a, pixel_port_b, pixel_port_c, active_video_in};
    end
  end

  // Routing, sync recovery and pixel formatting.
  always_comb begin
    logic [23:0] mr;
    logic [23:0] mf;
    logic [23:0] mc;
    logic        dbl;
    logic        fall;
    logic        emb;
    logic        trs;
    logic [7:0]  xy;
    logic        dv;
    logic        lst;
    dv   = 1'b0;
    trs  = 1'b0;
    xy   = 8'h00;
    lst  = 1'b0;
    mr   = route(pq.map, pixel_port_a, pixel_port_b, pixel_port_c);
    mf   = route(pq.map, nq.a, nq.b, nq.c);
    dbl  = pq.ctl.fmt == vic_pkg::FMT_ITL
        && pq.ctl.edg == vic_pkg::EDG_DBL;
    fall = pq.ctl.edg == vic_pkg::EDG_FALL;
    mc   = fall ? mf : mr;
    emb  = pq.ctl.emb;
    pd   = pq;
    pd.vld = 1'b0;
    pd.fst = 1'b0;
    pd.vs  = frame_sync_in;
    pd.hs  = line_sync_in;
    // Luma key history; timing codes always ride on channel 1.
    if (dbl) begin
      pd.key = {pq.key[1:0], mf[15:8], mr[15:8]};
    end else begin
      pd.key = {pq.key[2:0], mc[15:8]};
    end
    xy  = pd.key[0];
    trs = emb && pd.key[3] == vic_pkg::TRS_HI && pd.key[2] == vic_pkg::TRS_LO
       && pd.key[1] == vic_pkg::TRS_LO && xy_ok(xy, pq.ctl.strict);
    if (trs) begin
      pd.act = !xy[4] && !xy[5];
      pd.vb  = xy[5];
    end
    // With embedded sync, reserved code values on channel 1 never count as picture samples.
    if (emb) begin
      dv = pq.act && !trs && mc[15:8] != vic_pkg::TRS_HI
        && mc[15:8] != vic_pkg::TRS_LO
        && (!dbl || (mf[15:8] != vic_pkg::TRS_HI
        && mf[15:8] != vic_pkg::TRS_LO));
    end else begin
      dv = fall ? nq.de : active_video_in;
    end
    dv = dv && pq.ctl.en;
    if (!dv) begin
      pd.ph = 2'h0;
    end else begin
      case (pq.ctl.fmt)
        vic_pkg::FMT_ITL: begin
          if (dbl) begin
            pd.c0  = {mf[15:8], mf[3:0]};
            pd.c1  = {mr[15:8], mr[3:0]};
            pd.c2  = 12'h000;
            pd.odd = pq.ph[0];
            pd.vld = 1'b1;
            pd.ph  = pq.ph + 2'h1;
          end else begin
            pd.ph = pq.ph + 2'h1;
            if (!pq.ph[0]) begin
              pd.chr = {mc[15:8], mc[3:0]};
            end else begin
              pd.c0  = pq.chr;
              pd.c1  = {mc[15:8], mc[3:0]};
              pd.c2  = 12'h000;
              pd.odd = pq.ph[1];
              pd.vld = 1'b1;
            end
          end
        end
        vic_pkg::FMT_SEMI: begin
          pd.c0  = {mc[23:16], mc[7:4]};
          pd.c1  = {mc[15:8], mc[3:0]};
          pd.c2  = 12'h000;
          pd.odd = pq.ph[0];
          pd.vld = 1'b1;
          pd.ph  = pq.ph + 2'h1;
        end
        default: begin
          pd.c0  = {mc[7:0], 4'h0};
          pd.c1  = {mc[15:8], 4'h0};
          pd.c2  = {mc[23:16], 4'h0};
          pd.odd = 1'b0;
          pd.vld = 1'b1;
        end
      endcase
    end
    // Line counting and frame boundary, from pins or from timing codes.
    lst = emb ? (trs && xy[4]) : (line_sync_in && !pq.hs);
    bnd = emb ? (trs && xy[5] && !pq.vb)
              : (frame_sync_in && !pq.vs);
    if (lst) begin
      pd.lcnt = pq.lcnt + 11'h001;
    end
    if (bnd) begin
      pd.lines = pq.lcnt;
      pd.lcnt  = 11'h000;
      pd.ftg   = !pq.ftg;
      pd.fst   = 1'b1;
    end
    // A pending setting waits for the boundary unless capture is idle.
    if (pq.pend && (bnd || !pq.ctl.en)) begin
      pd.ctl  = pq.pctl;
      pd.map  = pq.pmap;
      pd.pend = 1'b0;
    end
    if (req_s != pq.ack) begin
      pd.pctl = rq.sctl;
      pd.pmap = rq.smap;
      pd.pend = 1'b1;
      pd.ack  = req_s;
    end
  end

  // Pixel-side state register.
  always_ff @(posedge pixel_clock_in or negedge rst_n) begin
    if (!rst_n) begin
      pq      <= '0;
      pq.ctl  <= vic_pkg::CTL_RST;
      pq.map  <= vic_pkg::MAP_RST;
      pq.pctl <= vic_pkg::CTL_RST;
      pq.pmap <= vic_pkg::MAP_RST;
    end else begin
      pq <= pd;
    end
  end

  // Outputs straight from state.
  assign avs_readdata    = rq.rdata;
  assign avs_waitrequest = rq.wt;
  assign target_addr_lsb = rq.strap;
  assign pix_ch0         = pq.c0;
  assign pix_ch1         = pq.c1;
  assign pix_ch2         = pq.c2;
  assign pix_odd         = pq.odd;
  assign pix_valid       = pq.vld;
  assign frame_start     = pq.fst;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_wait_one;
    @(posedge ref_clk) disable iff (!rst_n)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("Bus access not answered after one wait state.");

  property p_strap;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(rq.sok) |-> target_addr_lsb ==
      $past({target_addr_strap1, target_addr_strap0}, 3);
  endproperty
  a_strap: assert property (p_strap)
    else $error("Target address bits differ from the straps.");

  property p_cfg_hold;
    @(posedge pixel_clock_in) disable iff (!rst_n)
    (pq.ctl != $past(pq.ctl)) |-> ($past(bnd) || !$past(pq.ctl.en));
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("Capture setting changed inside a frame.");

  property p_rgb_map;
    @(posedge pixel_clock_in) disable iff (!rst_n)
    (pix_valid && pq.ctl.fmt == vic_pkg::FMT_RGB && $stable(pq.ctl)
     && pq.ctl.edg == vic_pkg::EDG_RISE && pq.map == vic_pkg::MAP_RST
     && $stable(pq.map))
    |-> (pix_ch0[11:4] == $past(pixel_port_a)
      && pix_ch1[11:4] == $past(pixel_port_b)
      && pix_ch2[11:4] == $past(pixel_port_c));
  endproperty
  a_rgb_map: assert property (p_rgb_map)
    else $error("Default RGB port mapping broken.");

  property p_rev;
    @(posedge pixel_clock_in) disable iff (!rst_n)
    (pix_valid && pq.ctl.fmt == vic_pkg::FMT_RGB && $stable(pq.ctl)
     && pq.ctl.edg == vic_pkg::EDG_RISE && pq.map.s0 == 2'h2
     && pq.map.rev[0] && $stable(pq.map))
    |-> pix_ch0[11:4] == rev8($past(pixel_port_c));
  endproperty
  a_rev: assert property (p_rev)
    else $error("Channel bit reversal not applied.");

  property p_ext_de;
    @(posedge pixel_clock_in) disable iff (!rst_n)
    ($past(pq.ctl) == vic_pkg::vic_ctl_t'(7'h01)
     && pq.ctl == vic_pkg::vic_ctl_t'(7'h01))
    |-> pix_valid == $past(active_video_in);
  endproperty
  a_ext_de: assert property (p_ext_de)
    else $error("Valid does not follow active video.");

  property p_fall;
    @(posedge pixel_clock_in) disable iff (!rst_n)
    ($past(pq.ctl) == vic_pkg::vic_ctl_t'(7'h09)
     && pq.ctl == vic_pkg::vic_ctl_t'(7'h09))
    |-> pix_valid == $past(nq.de);
  endproperty
  a_fall: assert property (p_fall)
    else $error("Falling-edge capture not used.");

  property p_emb;
    @(posedge pixel_clock_in) disable iff (!rst_n)
    (pix_valid && pq.ctl.emb && $stable(pq.ctl)) |-> $past(pq.act);
  endproperty
  a_emb: assert property (p_emb)
    else $error("Embedded-sync pixel outside active video.");

  property p_itl;
    @(posedge pixel_clock_in) disable iff (!rst_n)
    (pix_valid && pq.ctl.fmt == vic_pkg::FMT_ITL
     && pq.ctl.edg != vic_pkg::EDG_DBL) |=> !pix_valid;
  endproperty
  a_itl: assert property (p_itl)
    else $error("Interleaved single edge gave pixels back to back.");

  property p_dbl;
    @(posedge pixel_clock_in) disable iff (!rst_n)
    ($past(pq.ctl) == vic_pkg::vic_ctl_t'(7'h15)
     && pq.ctl == vic_pkg::vic_ctl_t'(7'h15) && $past(active_video_in))
    |-> pix_valid;
  endproperty
  a_dbl: assert property (p_dbl)
    else $error("Double-edge capture missed a pixel.");

  c_sav: cover property (@(posedge pixel_clock_in) disable iff (!rst_n)
    $rose(pq.act));
  c_apply: cover property (@(posedge pixel_clock_in) disable iff (!rst_n)
    $fell(pq.pend) && pq.ctl.en);
  c_dbl: cover property (@(posedge pixel_clock_in) disable iff (!rst_n)
    pix_valid && pq.ctl.edg == vic_pkg::EDG_DBL);

endmodule // vic_capture

// ---- src/vic_pkg.sv ----
// Purpose: Shared constants and types of the video input capture block.
// Assumes: One system clock domain and one pixel clock domain.
// Notes:   Register offsets are byte addresses of 32-bit words.
//
// Functional notes
// - Pixels arrive on three separate 8-bit ports, one input channel each.
// - Any port may feed any channel; each channel may bit-reverse its bus.
// - Capture on rising edge, falling edge, or both edges of pixel clock.
// - Double-edge capture takes two samples per pixel clock period.
// - One sample slot per pixel clock so a ten-times serializer keeps up.
// - RGB 4:4:4 uses single-edge capture, either sync kind, up to 150 MHz.
// - Luma/chroma 4:4:4 uses single-edge capture, either sync, to 150 MHz.
// - Interleaved 4:2:2 single-edge runs up to 54.054 MHz, to 480p/576p.
// - Double edge exists only for interleaved 4:2:2, up to 27.027 MHz.
// - Semi-planar 4:2:2 is single-edge, up to 148.5 MHz and 1080p.
// - Interleaved 4:2:2 accepted as strict 656 or 656-like, 12-bit words.
// - Hard reset while the active-low reset input is held low.
// - Two strap inputs give the two low bits of the bus target address.
// - Default RGB mapping: blue on port A, green on B, red on C.
// - Embedded sync ignores sync pins and decodes timing from the data.

package vic_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_MAP  = 5'h04;
  localparam logic [4:0] OFF_STAT = 5'h08;
  localparam logic [4:0] OFF_LIM  = 5'h0C;

  // ----------------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FMT_RGB  = 2'b00,
    FMT_YCC  = 2'b01,
    FMT_ITL  = 2'b10,
    FMT_SEMI = 2'b11
  } vic_fmt_t;

  typedef enum logic [1:0] {
    EDG_RISE = 2'b00,
    EDG_FALL = 2'b01,
    EDG_DBL  = 2'b10,
    EDG_RSVD = 2'b11
  } vic_edg_t;

  // Control word: bit 0 enable, 2:1 format, 4:3 edge, 5 embedded, 6 strict.
  typedef struct packed {
    logic     strict;
    logic     emb;
    vic_edg_t edg;
    vic_fmt_t fmt;
    logic     en;
  } vic_ctl_t;

  // Port map: 1:0 source of ch0, 3:2 ch1, 5:4 ch2, 8:6 reverse per channel.
  typedef struct packed {
    logic [2:0] rev;
    logic [1:0] s2;
    logic [1:0] s1;
    logic [1:0] s0;
  } vic_map_t;

  localparam vic_ctl_t CTL_RST = vic_ctl_t'(7'h00);
  localparam vic_map_t MAP_RST = vic_map_t'(9'h024);

  // ----------------------------------------------------------------------
  // Timing and code constants
  // ----------------------------------------------------------------------
  localparam logic [17:0] KHZ_444  = 18'h249F0; // 150 MHz.
  localparam logic [17:0] KHZ_ITL  = 18'h0D326; // 54.054 MHz.
  localparam logic [17:0] KHZ_DBL  = 18'h06993; // 27.027 MHz.
  localparam logic [17:0] KHZ_SEMI = 18'h24414; // 148.5 MHz.
  localparam logic [3:0]  SER_MULT = 4'hA;      // Serializer bits per sample.
  localparam logic [1:0]  STRAP_WAIT = 2'h3;
  localparam logic [7:0]  TRS_HI   = 8'hFF;
  localparam logic [7:0]  TRS_LO   = 8'h00;

endpackage

// ---- src/vic_sync2.sv ----
// Purpose: Two-flop synchroniser for levels and toggles.
// Assumes: Inputs are quasi-static or toggles slower than the clock.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module vic_sync2 #(
  parameter int W = 1
) (
  // Destination clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Asynchronous input and synchronised output.
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } vic_sy_t;

  vic_sy_t sq;
  vic_sy_t sd;

  // Shift the input through both stages.
  always_comb begin
    sd    = sq;
    sd.s1 = d;
    sd.s2 = sq.s1;
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sq <= '0;
    end else begin
      sq <= sd;
    end
  end

  assign q = sq.s2;

endmodule // vic_sync2

// ---- tb/tb_video_input_capture.sv ----
// Purpose: Self-checking bench of the capture block.
// Assumes: One wait state per bus access; RGB and interleaved frames.
// Notes:   Pixel checks run in the pixel clock domain.
`timescale 1ns/1ps
module tb_video_input_capture;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic        ref_clk, rst_n, avs_read, avs_write, go, busy, s0, s1;
  logic [2:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        avs_waitrequest, pclk, lsync, fsync, av, odd, valid, fst;
  logic [7:0]  pa, pb, pc;
  logic [11:0] ch0, ch1, ch2;
  logic [1:0]  lsb;
  int          n_mismatch, num_checks, k, nfs, m;
  logic [31:0] ctl [6] = '{32'h00, 32'h02, 32'h04, 32'h14, 32'h10, 32'h06};
  logic [31:0] lim [6] = '{32'(vic_pkg::KHZ_444), 32'(vic_pkg::KHZ_444),
    32'(vic_pkg::KHZ_ITL), 32'(vic_pkg::KHZ_DBL), 32'(vic_pkg::KHZ_444),
    32'(vic_pkg::KHZ_SEMI)};

  vic_capture i_vic_capture (.ref_clk(ref_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .target_addr_strap0(s0),
    .target_addr_strap1(s1), .target_addr_lsb(lsb), .pixel_clock_in(pclk),
    .pixel_port_a(pa), .pixel_port_b(pb), .pixel_port_c(pc),
    .line_sync_in(lsync), .frame_sync_in(fsync), .active_video_in(av),
    .pix_ch0(ch0), .pix_ch1(ch1), .pix_ch2(ch2), .pix_odd(odd),
    .pix_valid(valid), .frame_start(fst));
  vic_src i_vic_src (.go(go), .busy(busy), .pixel_clock_in(pclk),
    .pixel_port_a(pa), .pixel_port_b(pb), .pixel_port_c(pc),
    .line_sync_in(lsync), .frame_sync_in(fsync), .active_video_in(av));

  // The clock toggles every 10 ns, half of its 20 ns period.
  always #10 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string s, input logic [35:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  // Request is held until waitrequest is sampled low at an edge.
  task automatic bus(input logic w, input logic [4:0] o, input int d);
    @(posedge ref_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= o[4:2];
    avs_writedata <= d;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] o, input logic [31:0] e, string s);
    bus(1'b0, o, 0);
    chk(s, 36'(e), 36'(q));
  endtask
  task automatic frame(input int md, input int n);
    m = md;
    k = 0;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    do @(posedge ref_clk); while (busy !== 1'b0);
    chk("pixel count", 36'(n), 36'(k));
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Mode 2 pairs words 2i and 2i+1 of the mode 1 routing into one pixel.
  function automatic logic [35:0] px(input int i, md);
    logic [7:0]  a, b, c, r;
    logic [35:0] w0, w1;
    a = {i[3:0], ~i[3:0]};
    b = a ^ 8'h5A;
    c = a + 8'h33;
    r = {<<{c}};
    if (md == 0) return {c, 4'h0, b, 4'h0, a, 4'h0};
    if (md == 1) return {b, 4'h0, a, 4'h0, r, 4'h0};
    w0 = px(2 * i, 1);
    w1 = px(2 * i + 1, 1);
    return {12'h000, w1[23:16], w1[7:4], w0[23:16], w0[7:4]};
  endfunction

  // Each valid pixel is compared with the pattern the source sent.
  always @(posedge pclk) begin
    if (fst === 1'b1) nfs++;
    if (valid === 1'b1) begin
      chk("pixel", px(k, m), {ch2, ch1, ch0});
      chk("pixel odd", 36'(m == 2 && k[0]), 36'(odd));
      k++;
    end
  end

  // ----------------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    #200000;
    n_mismatch++;
    test_done();
  end
  initial begin
    {ref_clk, rst_n, avs_read, avs_write, go, s0, s1} = 7'h02;
    {avs_address, avs_writedata, n_mismatch, num_checks, nfs} = '0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(vic_pkg::OFF_CTRL, 32'h00, "ctrl reset");
    rd(vic_pkg::OFF_MAP, 32'h024, "map reset");
    bus(1'b1, 5'h10, 32'hFFFFFFFF);
    rd(5'h10, 32'h0, "unmapped");
    bus(1'b0, vic_pkg::OFF_STAT, 0);
    chk("strap status", 36'h2, 36'(q[2:0] & 3'h6));
    chk("target lsb", 36'h1, 36'(lsb));
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, vic_pkg::OFF_CTRL, ctl[i]);
      rd(vic_pkg::OFF_LIM, lim[i], "limit");
    end
    bus(1'b1, vic_pkg::OFF_CTRL, 32'h01);
    frame(0, 8);
    bus(1'b1, vic_pkg::OFF_MAP, 32'h052);
    frame(1, 8);
    bus(1'b1, vic_pkg::OFF_CTRL, 32'h09);
    frame(1, 8);
    bus(1'b1, vic_pkg::OFF_CTRL, 32'h05);
    frame(2, 4);
    rd(vic_pkg::OFF_STAT, 32'h00010402, "status");
    chk("frame starts", 36'd4, 36'(nfs));
    test_done();
  end
endmodule // tb_video_input_capture

// ---- tb/vic_src.sv ----
// Purpose: Behavioural video source that sends one frame per go pulse.
// Assumes: Data change 5 ns after the falling edge, so both edges see them.
// Notes:   Clock stands still between frames; idle data toggles.
`timescale 1ns/1ps
module vic_src #(
  parameter int N = 8
) (
  // Frame request and activity flag.
  input  wire logic go,
  output logic      busy,
  // Pixel clock, ports and sync pins.
  output logic       pixel_clock_in,
  output logic [7:0] pixel_port_a,
  output logic [7:0] pixel_port_b,
  output logic [7:0] pixel_port_c,
  output logic       line_sync_in,
  output logic       frame_sync_in,
  output logic       active_video_in
);
  // ----------------------------------------------------------------------
  // Frame generator
  // ----------------------------------------------------------------------
  initial begin
    {busy, pixel_clock_in, line_sync_in, frame_sync_in} = 4'h0;
    active_video_in = 1'b0;
    {pixel_port_a, pixel_port_b, pixel_port_c} = 24'h0;
  end
  // Long lead lets settings cross before the frame edge; one clock only.
  always @(posedge go) begin
    busy = 1'b1;
    for (int i = -10; i < N + 3; i++) begin
      frame_sync_in = (i == -2);
      line_sync_in = (i == -1);
      active_video_in = (i >= 0 && i < N);
      if (i >= 0 && i < N) begin
        pixel_port_a = {i[3:0], ~i[3:0]};
        pixel_port_b = pixel_port_a ^ 8'h5A;
        pixel_port_c = pixel_port_a + 8'h33;
      end else begin
        {pixel_port_a, pixel_port_b} = ~{pixel_port_a, pixel_port_b};
        pixel_port_c = ~pixel_port_c;
      end
      #10 pixel_clock_in = 1'b1;
      #15 pixel_clock_in = 1'b0;
      #5;
    end
    busy = 1'b0;
  end
endmodule // vic_src
